// ---- core/ccl_comparator_ctrl.sv ----
// Control logic for three comparator channels: enables, settings, edges and interrupt.
// What this block does
// - Three independent channels, each enabled or shut down separately.
// - On bit at 1 enables a comparator, at 0 disables it.
// - Disabled comparator drives its port output low.
// - Output usable for software read, interrupt, reset source, port pin.
// - Live result readable any time without side effects.
// - Two-bit response speed field selects comparator response time.
// - Two two-bit hysteresis fields set upper and lower hysteresis.
// - Rising and falling output transitions are both detected.
// - Rise and fall enables select which edges request interrupts.
// - Interrupt reaches processor only with the global comparator enable.
// - Falling edge sets fall flag; rising edge sets rise flag.
`timescale 1ns/1ps
`default_nettype none
module ccl_comparator_ctrl (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Software configuration writes, one strobe per channel
  input wire logic [2:0] cfg_we_in,
  input wire ccl_pkg::ccl_cfg_type cfg_wdata_in,
  // Software flag clears, one pair per channel
  input wire logic [2:0] rise_clr_in,
  input wire logic [2:0] fall_clr_in,
  // Global comparator interrupt enables, one per channel
  input wire logic [2:0] ext_irq_allow_in,
  // Raw comparator outputs from the analog cores
  input wire logic [2:0] raw_result_in,
  // Analog core controls
  output ccl_pkg::ccl_cfg_type [2:0] cfg_out,
  // Status for software
  output ccl_pkg::ccl_stat_type [2:0] stat_out,
  // Interrupt requests, reset source and port pin outputs
  output logic [2:0] irq_out,
  output logic [2:0] reset_src_out,
  output logic [2:0] pin_out
);
  localparam ccl_pkg::ccl_cfg_type CFG_RESET = '{
    on: 1'b0,
    upper_hysteresis_sel: 2'h0,
    lower_hysteresis_sel: 2'h0,
    response_speed_sel: ccl_pkg::SPEED_RESET,
    rise_irq_allow: 1'b0,
    fall_irq_allow: 1'b0
  };

  ccl_pkg::ccl_cfg_type [2:0] cfg_q;
  logic [2:0] level;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] rise_flag;
  logic [2:0] fall_flag;
  logic [2:0] pin_q;
  logic [2:0] reset_q;
  logic [2:0] irq_q;

  assign cfg_out = cfg_q;

  genvar ch;
  generate
    for (ch = 0; ch < ccl_pkg::NUM_CH; ch++) begin : g_ch
      always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
          cfg_q[ch] <= CFG_RESET;
        end else if (cfg_we_in[ch]) begin
          cfg_q[ch] <= cfg_wdata_in;
        end
      end

      ccl_edge_detect u_edge (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .raw_in(raw_result_in[ch]),
        .on_in(cfg_q[ch].on),
        .level_out(level[ch]),
        .rise_out(rise[ch]),
        .fall_out(fall[ch])
      );

      ccl_flag u_rise (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .set_in(rise[ch]),
        .clr_in(rise_clr_in[ch]),
        .flag_out(rise_flag[ch])
      );

      ccl_flag u_fall (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .set_in(fall[ch]),
        .clr_in(fall_clr_in[ch]),
        .flag_out(fall_flag[ch])
      );

      assign stat_out[ch].compare_result = level[ch];
      assign stat_out[ch].rise_event_flag = rise_flag[ch];
      assign stat_out[ch].fall_event_flag = fall_flag[ch];
    end
  endgenerate

  logic [2:0] irq_d;
  logic [2:0] rise_allow;
  logic [2:0] fall_allow;
  assign rise_allow = {cfg_q[2].rise_irq_allow, cfg_q[1].rise_irq_allow,
                       cfg_q[0].rise_irq_allow};
  assign fall_allow = {cfg_q[2].fall_irq_allow, cfg_q[1].fall_irq_allow,
                       cfg_q[0].fall_irq_allow};
  // Request stays up while an allowed flag is pending.
  assign irq_d = ((rise_flag & rise_allow) | (fall_flag & fall_allow))
                 & ext_irq_allow_in;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pin_q <= 3'h0;
      reset_q <= 3'h0;
      irq_q <= 3'h0;
    end else begin
      pin_q <= level;
      reset_q <= level;
      irq_q <= irq_d;
    end
  end

  assign pin_out = pin_q;
  assign reset_src_out = reset_q;
  assign irq_out = irq_q;

  // Checks.
  a_pin_low_off: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !cfg_q[0].on |=> !pin_q[0])
    else $error("pin not low while off");

  a_rise_sets: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    rise[0] |=> rise_flag[0])
    else $error("rise flag not set");

  a_fall_sets: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    fall[1] |=> fall_flag[1])
    else $error("fall flag not set");

  a_no_edge_off: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !cfg_q[2].on |-> !(rise[2] | fall[2]))
    else $error("edge while off");

  a_irq_gated: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !ext_irq_allow_in[0] |=> !irq_q[0])
    else $error("irq without global");

  a_irq_rise: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (rise_flag[1] && cfg_q[1].rise_irq_allow && ext_irq_allow_in[1]) |=> irq_q[1])
    else $error("irq missing on rise");

  a_cfg_write: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    cfg_we_in[0] |=> cfg_q[0].on == $past(cfg_wdata_in.on))
    else $error("on not stored");

  a_edge_level: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    rise[1] |-> level[1])
    else $error("rise with low level");

  // A detected edge, then one cycle later both its own and the global gate open.
  sequence s_edge_then_gates(ev, allow_bit, glob_bit);
    ev ##1 (allow_bit && glob_bit);
  endsequence

  // The channel was off and has just been switched on.
  sequence s_step_on(on_bit);
    !on_bit ##1 on_bit;
  endsequence

  // A clear arrives with no competing event in the same cycle.
  sequence s_clear_only(clr_bit, ev);
    clr_bit && !ev;
  endsequence

  // Every channel carries the same checks, so no channel is left unwatched.
  generate
    for (ch = 0; ch < ccl_pkg::NUM_CH; ch++) begin : g_chk
      a_rise_flag_set: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        rise[ch] |=> rise_flag[ch])
        else $error("rise flag not raised");

      a_fall_flag_set: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        fall[ch] |=> fall_flag[ch])
        else $error("fall flag not raised");

      a_rise_set_wins: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (rise[ch] && rise_clr_in[ch]) |=> rise_flag[ch])
        else $error("clear beat rise event");

      a_fall_set_wins: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (fall[ch] && fall_clr_in[ch]) |=> fall_flag[ch])
        else $error("clear beat fall event");

      a_rise_flag_clear: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_clear_only(rise_clr_in[ch], rise[ch]) |=> !rise_flag[ch])
        else $error("rise flag not cleared");

      a_fall_flag_clear: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_clear_only(fall_clr_in[ch], fall[ch]) |=> !fall_flag[ch])
        else $error("fall flag not cleared");

      a_rise_flag_holds: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (rise_flag[ch] && !rise_clr_in[ch]) |=> rise_flag[ch])
        else $error("rise flag lost");

      a_fall_flag_holds: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (fall_flag[ch] && !fall_clr_in[ch]) |=> fall_flag[ch])
        else $error("fall flag lost");

      a_rise_no_spur: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (!rise_flag[ch] && !rise[ch]) |=> !rise_flag[ch])
        else $error("rise flag without event");

      a_fall_no_spur: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (!fall_flag[ch] && !fall[ch]) |=> !fall_flag[ch])
        else $error("fall flag without event");

      a_edge_off_none: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !cfg_q[ch].on |-> !(rise[ch] || fall[ch]))
        else $error("edge seen while off");

      a_edge_one_way: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !(rise[ch] && fall[ch]))
        else $error("rise and fall together");

      a_enable_quiet: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_step_on(cfg_q[ch].on) |-> !(rise[ch] || fall[ch]))
        else $error("edge on enabling cycle");

      a_level_off_low: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !cfg_q[ch].on |-> !level[ch])
        else $error("result high while off");

      a_pin_high: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        level[ch] |=> pin_q[ch])
        else $error("pin missed high result");

      a_pin_low: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !level[ch] |=> !pin_q[ch])
        else $error("pin high on low result");

      a_reset_high: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        level[ch] |=> reset_q[ch])
        else $error("reset source missed result");

      a_reset_low: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !level[ch] |=> !reset_q[ch])
        else $error("reset source high on low result");

      a_rise_path: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_edge_then_gates(rise[ch], cfg_q[ch].rise_irq_allow, ext_irq_allow_in[ch])
        |=> irq_q[ch])
        else $error("rise did not request irq");

      a_fall_path: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        s_edge_then_gates(fall[ch], cfg_q[ch].fall_irq_allow, ext_irq_allow_in[ch])
        |=> irq_q[ch])
        else $error("fall did not request irq");

      a_irq_quiet: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        (!rise_flag[ch] && !fall_flag[ch]) |=> !irq_q[ch])
        else $error("irq with no pending flag");

      a_irq_global: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !ext_irq_allow_in[ch] |=> !irq_q[ch])
        else $error("irq without global enable");

      a_cfg_load: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        cfg_we_in[ch] |=> cfg_q[ch] == $past(cfg_wdata_in))
        else $error("settings not stored");

      a_cfg_hold: assert property (
        @(posedge clk_in) disable iff (!rst_b_in)
        !cfg_we_in[ch] |=> $stable(cfg_q[ch]))
        else $error("settings changed without write");
    end
  endgenerate
endmodule // ccl_comparator_ctrl
`default_nettype wire

// ---- include/ccl_pkg.sv ----
// Shared constants and carrier types for the comparator control logic.
package ccl_pkg;
  localparam int NUM_CH = 3;
  // Control register field positions.
  localparam int CTL_ON_BIT = 7;
  localparam int CTL_RESULT_BIT = 6;
  localparam int CTL_RISE_FLAG_BIT = 5;
  localparam int CTL_FALL_FLAG_BIT = 4;
  localparam int CTL_HYP_LSB = 2;
  localparam int CTL_HYN_LSB = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Mode register field positions.
  localparam int MD_RISE_IE_BIT = 5;
  localparam int MD_FALL_IE_BIT = 4;
  localparam int MD_SPEED_LSB = 0;
  localparam logic [7:0] MD_RESET = 8'h02;
  localparam logic [1:0] SPEED_RESET = 2'h2;

  typedef struct packed {
    logic on;
    logic [1:0] upper_hysteresis_sel;
    logic [1:0] lower_hysteresis_sel;
    logic [1:0] response_speed_sel;
    logic rise_irq_allow;
    logic fall_irq_allow;
  } ccl_cfg_type;

  typedef struct packed {
    logic compare_result;
    logic rise_event_flag;
    logic fall_event_flag;
  } ccl_stat_type;
endpackage

// ---- core/ccl_edge_detect.sv ----
// Synchroniser and edge detector for one comparator output.
`timescale 1ns/1ps
`default_nettype none
module ccl_edge_detect (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Analog side
  input wire logic raw_in,
  input wire logic on_in,
  // Detected state
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  logic valid_q;
  logic gated;

  // Disabled channel reads low and never produces an edge.
  assign gated = sync_q & on_in;
  assign level_out = gated;
  assign rise_out = valid_q & on_in & sync_q & ~prev_q;
  assign fall_out = valid_q & on_in & ~sync_q & prev_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      // Previous sample is only trusted once a full enabled cycle passed.
      valid_q <= on_in;
    end
  end
endmodule // ccl_edge_detect
`default_nettype wire

// ---- core/ccl_flag.sv ----
// Sticky event flag with set priority over clear.
`timescale 1ns/1ps
`default_nettype none
module ccl_flag (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Control
  input wire logic set_in,
  input wire logic clr_in,
  // State
  output logic flag_out
);
  logic flag_q;
  logic flag_d;

  assign flag_d = set_in ? 1'b1 : (clr_in ? 1'b0 : flag_q);
  assign flag_out = flag_q;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule // ccl_flag
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the three-channel comparator control logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t: got %0h want %0h", $time, (a), (b)); end end
module testbench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [2:0] cfg_we_in = 3'h0;
  ccl_pkg::ccl_cfg_type cfg_wdata_in = '0;
  logic [2:0] rise_clr_in = 3'h0;
  logic [2:0] fall_clr_in = 3'h0;
  logic [2:0] ext_irq_allow_in = 3'h0;
  logic [2:0] raw_result_in = 3'h0;
  ccl_pkg::ccl_cfg_type [2:0] cfg_out;
  ccl_pkg::ccl_stat_type [2:0] stat_out;
  logic [2:0] irq_out;
  logic [2:0] reset_src_out;
  logic [2:0] pin_out;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  ccl_comparator_ctrl dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_we_in(cfg_we_in),
    .cfg_wdata_in(cfg_wdata_in), .rise_clr_in(rise_clr_in), .fall_clr_in(fall_clr_in),
    .ext_irq_allow_in(ext_irq_allow_in), .raw_result_in(raw_result_in), .cfg_out(cfg_out),
    .stat_out(stat_out), .irq_out(irq_out), .reset_src_out(reset_src_out), .pin_out(pin_out));

  always #2.5 clk_in = ~clk_in;

  // A hang is cut short well beyond the 177 cycles the scenarios need.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles > 3000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic wr(input int ch, input ccl_pkg::ccl_cfg_type c);
    cfg_wdata_in <= c;
    cfg_we_in <= 3'h1 << ch;
    cyc(1);
    cfg_we_in <= 3'h0;
    cyc(1);
    `CHK(cfg_out[ch], c)
  endtask

  task automatic clr(input int ch);
    rise_clr_in <= 3'h1 << ch;
    fall_clr_in <= 3'h1 << ch;
    cyc(1);
    rise_clr_in <= 3'h0;
    fall_clr_in <= 3'h0;
    cyc(2);
  endtask

  task automatic check_reset();
    for (int ch = 0; ch < 3; ch++) begin
      `CHK(cfg_out[ch].response_speed_sel, ccl_pkg::SPEED_RESET)
      `CHK(cfg_out[ch].on, 1'b0)
      `CHK(stat_out[ch], 3'h0)
    end
    `CHK(irq_out, 3'h0)
    `CHK(pin_out, 3'h0)
  endtask

  // Rising and falling edges on one channel; global and rise interrupt gates tested open and shut, fall gate only open.
  task automatic edge_chan(input int ch);
    ext_irq_allow_in <= 3'h1 << ch;
    wr(ch, '{1'b1, 2'(ch + 1), 2'(3 - ch), 2'(ch), 1'b1, 1'b1});
    cyc(3);
    raw_result_in[ch] <= 1'b1;
    cyc(6);
    `CHK(stat_out[ch], 3'h6)
    `CHK(pin_out, 3'h1 << ch)
    `CHK(reset_src_out, 3'h1 << ch)
    `CHK(irq_out, 3'h1 << ch)
    clr(ch);
    `CHK(irq_out, 3'h0)
    ext_irq_allow_in <= 3'h0;
    raw_result_in[ch] <= 1'b0;
    cyc(6);
    `CHK(stat_out[ch], 3'h1)
    `CHK(irq_out, 3'h0)
    ext_irq_allow_in <= 3'h1 << ch;
    cyc(3);
    `CHK(irq_out, 3'h1 << ch)
    clr(ch);
    wr(ch, '{1'b1, 2'h0, 2'h0, 2'h3, 1'b0, 1'b1});
    raw_result_in[ch] <= 1'b1;
    cyc(6);
    `CHK(stat_out[ch], 3'h6)
    `CHK(irq_out, 3'h0)
    clr(ch);
    wr(ch, '{1'b0, 2'h0, 2'h0, 2'h3, 1'b1, 1'b1});
    cyc(6);
    `CHK(stat_out[ch], 3'h0)
    `CHK(pin_out, 3'h0)
    `CHK(irq_out, 3'h0)
    raw_result_in[ch] <= 1'b0;
    cyc(4);
    `CHK(stat_out[ch], 3'h0)
  endtask

  // Reset in mid-run clears pending flags, settings and requests.
  task automatic mid_reset();
    ext_irq_allow_in <= 3'h1;
    wr(0, '{1'b1, 2'h1, 2'h2, 2'h1, 1'b1, 1'b0});
    cyc(3);
    raw_result_in[0] <= 1'b1;
    cyc(6);
    `CHK(irq_out, 3'h1)
    rst_b_in <= 1'b0;
    cyc(2);
    rst_b_in <= 1'b1;
    `CHK(stat_out[0], 3'h0)
    `CHK(cfg_out[0].on, 1'b0)
    `CHK(irq_out, 3'h0)
    cyc(4);
    `CHK(stat_out[0], 3'h0)
    `CHK(pin_out, 3'h0)
    `CHK(reset_src_out, 3'h0)
    raw_result_in[0] <= 1'b0;
    ext_irq_allow_in <= 3'h0;
    cyc(4);
  endtask

  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    cyc(8);
    check_reset();
    rst_b_in <= 1'b1;
    cyc(1);
    for (int ch = 0; ch < 3; ch++) begin
      edge_chan(ch);
    end
    mid_reset();
    close_out();
  end
endmodule // testbench
`default_nettype wire
